// [design/vcl_pkg.sv]
/*
 * Constants shared by the velocity command limiter: object indices,
 * sub-indices, status bit positions, reset values and timing.
 * Assumes a single 40 MHz clock and a 32-bit dictionary access port.
 */
package vcl_pkg;

    // timing
    localparam int VCL_CLK_HZ = 40_000_000;
    localparam int VCL_SERVO_HZ = 3000;
    localparam int VCL_SERVO_CYC = VCL_CLK_HZ / VCL_SERVO_HZ;
    localparam int VCL_TIMEOUT_UNIT_HZ = 1000;
    localparam int VCL_MS_CYC = VCL_CLK_HZ / VCL_TIMEOUT_UNIT_HZ;

    // units: velocity in 0.1 counts/s, rates in 1000 counts/s^2
    localparam int VCL_VEL_PER_CPS = 10;
    localparam int VCL_RATE_UNIT = 1000;
    localparam int VCL_STEP_SH = 16;
    localparam int VCL_GAIN_SH = 8;

    ////////////////////////////////////////////////////////////////////////
    // dictionary object indices
    localparam logic [15:0] VCL_IDX_STATUS = 16'h1002;
    localparam logic [15:0] VCL_IDX_MAX_ACCEL = 16'h2100;
    localparam logic [15:0] VCL_IDX_MAX_DECEL = 16'h2101;
    localparam logic [15:0] VCL_IDX_DECEL_ALIAS = 16'h60C6;
    localparam logic [15:0] VCL_IDX_ESTOP_DECEL = 16'h2102;
    localparam logic [15:0] VCL_IDX_MAX_VEL = 16'h2103;
    localparam logic [15:0] VCL_IDX_ERR_WIN = 16'h2104;
    localparam logic [15:0] VCL_IDX_WIN_TIME = 16'h2105;
    localparam logic [15:0] VCL_IDX_OUT_FILT = 16'h2106;
    localparam logic [15:0] VCL_IDX_CMD_FILT = 16'h2108;
    localparam logic [15:0] VCL_IDX_LIMITED_VEL = 16'h2230;
    localparam logic [15:0] VCL_IDX_VEL_ERROR = 16'h2233;
    localparam logic [15:0] VCL_IDX_GAINS = 16'h2381;
    localparam logic [15:0] VCL_IDX_VEL_CMD = 16'h606B;
    localparam logic [15:0] VCL_IDX_POS_EFFORT = 16'h60FA;

    localparam logic [7:0] VCL_SUB_MAIN = 8'h00;
    localparam logic [7:0] VCL_SUB_KP = 8'h01;
    localparam logic [7:0] VCL_SUB_KI = 8'h02;
    localparam logic [7:0] VCL_SUB_FILT_SHIFT = 8'h01;

    // status word bits
    localparam int VCL_STAT_WRAP_BIT = 21;
    localparam int VCL_STAT_VWIN_BIT = 28;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0] VCL_RST_RATE = 32'hFFFF_FFFF;
    localparam logic [31:0] VCL_RST_MAX_VEL = 32'h7FFF_FFFF;
    localparam logic [31:0] VCL_RST_ERR_WIN = 32'h7FFF_FFFF;
    localparam logic [15:0] VCL_RST_WIN_TIME = 16'h0000;
    localparam logic [15:0] VCL_RST_GAIN = 16'h0000;
    localparam logic [3:0] VCL_RST_FILT_SHIFT = 4'h0;
    localparam logic [31:0] VCL_RST_POS_WRAP = 32'h0100_0000;

    // saturation bounds
    localparam logic signed [31:0] VCL_S32_MAX = 32'sh7FFF_FFFF;
    localparam logic signed [63:0] VCL_S64_HI = 64'sh0000_0000_7FFF_FFFF;
    localparam logic signed [63:0] VCL_S64_LO = 64'shFFFF_FFFF_8000_0000;

endpackage

// [design/vcl_filter.sv]
/*
 * First-order low-pass filter stage, y += (x - y) >>> shift, updated
 * once per enable pulse. Shift zero passes the input straight through.
 * Assumes x is saturated 32-bit signed and en is a one-cycle pulse.
 */
`timescale 1ns/100ps

module vcl_filter #(
    parameter int W = 32
) (
    input wire logic clk_i, // system clock
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic en_i, // servo update pulse
    input wire logic [3:0] shift_i, // smoothing shift, 0 = bypass
    input wire logic signed [W-1:0] x_i, // filter input
    output logic signed [W-1:0] y_o // filtered value
);

    logic signed [W:0] diff;
    logic signed [W:0] step;
    logic signed [W:0] sum;

    assign diff = (W+1)'(x_i) - (W+1)'(y_o);
    assign step = diff >>> shift_i;
    assign sum = (W+1)'(y_o) + step;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            y_o <= '0;
        end else if (en_i) begin
            y_o <= (shift_i == 4'h0) ? x_i : sum[W-1:0];
        end
    end

endmodule // vcl_filter

// [design/vcl_limiter.sv]
/*
 * Velocity loop front end: source select, maximum velocity clamp,
 * acceleration, deceleration and e-stop ramps on the alternate source only, command filter, error
 * against motor velocity, PI gains, output filter, tracking window and
 * modulo position counter, with a dictionary object access port.
 * Assumes all inputs come from logic on clk_i; accesses are one-cycle.
 */
`timescale 1ns/100ps

module vcl_limiter
    import vcl_pkg::*;
#(
    parameter int SERVO_HZ = vcl_pkg::VCL_SERVO_HZ,
    parameter int SERVO_CYC = vcl_pkg::VCL_SERVO_CYC,
    parameter int MS_CYC = vcl_pkg::VCL_MS_CYC,
    parameter logic [31:0] POS_WRAP = vcl_pkg::VCL_RST_POS_WRAP
) (
    input wire logic clk_i, // 40 MHz clock
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic obj_rd_i, // object read strobe
    input wire logic obj_wr_i, // object write strobe
    input wire logic [15:0] obj_index_i, // object index
    input wire logic [7:0] obj_subidx_i, // object sub-index
    input wire logic [31:0] obj_wdata_i, // write data
    output logic obj_ack_o, // access done pulse
    output logic obj_err_o, // unmapped or read-only pulse
    output logic [31:0] obj_rdata_o, // read data
    input wire logic alt_src_i, // 1 = alternate command source
    input wire logic signed [31:0] pos_loop_vel_i, // position loop out
    input wire logic signed [31:0] alt_vel_i, // alternate command
    input wire logic estop_i, // actively stopping before brake
    input wire logic signed [31:0] motor_vel_i, // motor encoder velocity
    input wire logic signed [15:0] enc_delta_i, // counts per servo cycle
    output logic servo_tick_o, // servo update pulse
    output logic signed [31:0] limited_vel_o, // filtered limited cmd
    output logic signed [31:0] vel_error_o, // velocity error
    output logic signed [31:0] cur_cmd_o, // filtered current command
    output logic vel_window_o, // velocity window flag
    output logic [31:0] pos_count_o, // modulo position count
    output logic pos_wrap_o // sticky wrap flag
);
    import vcl_pkg::*;

    localparam logic [63:0] STEP_K =
        64'((longint'(VCL_RATE_UNIT) * VCL_VEL_PER_CPS
        << VCL_STEP_SH) / SERVO_HZ);
    localparam logic [23:0] SERVO_LAST = 24'(SERVO_CYC - 1);
    localparam logic [23:0] MS_LAST = 24'(MS_CYC - 1);

    function automatic logic signed [31:0] sat32(
        input logic signed [63:0] v);
        if (v > VCL_S64_HI) return VCL_S32_MAX;
        if (v < VCL_S64_LO) return VCL_S64_LO[31:0];
        return v[31:0];
    endfunction

    function automatic logic signed [63:0] ext(input logic signed [31:0] v);
        return 64'(v);
    endfunction

    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        logic signed [63:0] a;
        a = (v < 0) ? -ext(v) : ext(v);
        return a[31:0];
    endfunction

    // velocity change allowed in one servo cycle for a given rate
    function automatic logic signed [31:0] rate_step(input logic [31:0] r);
        logic [63:0] p;
        p = (64'(r) * STEP_K) >> VCL_STEP_SH;
        return (p > 64'(VCL_S32_MAX)) ? VCL_S32_MAX : p[31:0];
    endfunction

    function automatic logic signed [31:0] gain(
        input logic signed [31:0] e, input logic [15:0] k);
        logic signed [63:0] p;
        p = (ext(e) * $signed({48'h0, k})) >>> VCL_GAIN_SH;
        return sat32(p);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] accel_reg, decel_reg, estop_reg, vmax_reg, win_reg;
    logic [15:0] win_time_reg, kp_reg, ki_reg;
    logic [3:0] cmd_shift_reg, out_shift_reg;
    logic signed [31:0] lim_reg, vcmd_reg, effort_reg, integ_reg;
    logic [23:0] servo_cnt_reg, ms_cnt_reg;
    logic [15:0] win_ms_reg;
    logic signed [31:0] filt_cmd, filt_cur;

    ////////////////////////////////////////////////////////////////////////
    // servo and millisecond enables
    logic tick, ms_tick, outside;
    assign tick = (servo_cnt_reg == SERVO_LAST);
    assign ms_tick = (ms_cnt_reg == MS_LAST);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            servo_cnt_reg <= '0;
            ms_cnt_reg <= '0;
            servo_tick_o <= 1'b0;
        end else begin
            servo_cnt_reg <= tick ? '0 : servo_cnt_reg + 24'h1;
            // restart while outside so only whole ms count toward timeout
            ms_cnt_reg <= (ms_tick || outside) ? '0 : ms_cnt_reg + 24'h1;
            servo_tick_o <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command limiter
    logic signed [31:0] raw_sel, vmax_s, clamped, target, tgt_eff;
    logic signed [31:0] step, ramped, lim_next;
    logic signed [63:0] diff;
    logic opposite, moving_out;
    logic [31:0] rate;

    assign raw_sel = alt_src_i ? alt_vel_i : pos_loop_vel_i;
    assign vmax_s = vmax_reg[31] ? VCL_S32_MAX : $signed(vmax_reg);
    assign clamped = (raw_sel > vmax_s) ? vmax_s :
        (raw_sel < -vmax_s) ? -vmax_s : raw_sel;
    assign target = estop_i ? '0 : clamped;
    assign opposite = (lim_reg != 0) && (target != 0) &&
        (target[31] != lim_reg[31]);
    // reverse through zero: slow down to zero first
    assign tgt_eff = opposite ? '0 : target;
    assign moving_out = ((tgt_eff > lim_reg) && (lim_reg >= 0)) ||
        ((tgt_eff < lim_reg) && (lim_reg <= 0));
    assign rate = estop_i ? estop_reg :
        moving_out ? accel_reg : decel_reg;
    assign step = rate_step(rate);
    assign diff = ext(tgt_eff) - ext(lim_reg);
    assign ramped = (diff > ext(step)) ? sat32(ext(lim_reg) + ext(step)) :
        (diff < -ext(step)) ? sat32(ext(lim_reg) - ext(step)) : tgt_eff;
    assign lim_next = alt_src_i ? ramped : clamped;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lim_reg <= '0;
            vcmd_reg <= '0;
            effort_reg <= '0;
        end else if (tick) begin
            lim_reg <= lim_next;
            vcmd_reg <= raw_sel;
            if (!alt_src_i) begin
                effort_reg <= pos_loop_vel_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command filter, error, PI and output filter
    vcl_filter #(.W(32)) u_cmd_filt (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(tick),
        .shift_i(cmd_shift_reg),
        .x_i(lim_next),
        .y_o(filt_cmd)
    );

    logic signed [31:0] err_next, integ_next, pi_out;
    assign err_next = sat32(ext(filt_cmd) - ext(motor_vel_i));
    assign integ_next = sat32(ext(integ_reg) + ext(gain(vel_error_o,
        ki_reg)));
    assign pi_out = sat32(ext(gain(vel_error_o, kp_reg)) +
        ext(integ_reg));

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            vel_error_o <= '0;
            integ_reg <= '0;
            limited_vel_o <= '0;
            cur_cmd_o <= '0;
        end else begin
            limited_vel_o <= filt_cmd;
            cur_cmd_o <= filt_cur;
            if (tick) begin
                vel_error_o <= err_next;
                integ_reg <= integ_next;
            end
        end
    end

    vcl_filter #(.W(32)) u_out_filt (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(tick),
        .shift_i(out_shift_reg),
        .x_i(pi_out),
        .y_o(filt_cur)
    );

    ////////////////////////////////////////////////////////////////////////
    // tracking window
    assign outside = abs32(vel_error_o) > win_reg;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            vel_window_o <= 1'b0;
            win_ms_reg <= '0;
        end else if (outside) begin
            vel_window_o <= 1'b1;
            win_ms_reg <= '0;
        end else if (vel_window_o) begin
            if (win_ms_reg >= win_time_reg) begin
                vel_window_o <= 1'b0;
            end else if (ms_tick) begin
                win_ms_reg <= win_ms_reg + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modulo position count
    logic signed [33:0] pos_sum;
    logic pos_under, pos_over, wrap_now, stat_rd;
    assign pos_sum = $signed({2'b00, pos_count_o}) + 34'(enc_delta_i);
    assign pos_under = pos_sum < 0;
    assign pos_over = pos_sum >= $signed({2'b00, POS_WRAP});
    assign wrap_now = tick && (pos_under || pos_over);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pos_count_o <= '0;
            pos_wrap_o <= 1'b0;
        end else begin
            if (tick) begin
                pos_count_o <= pos_under ?
                    32'(pos_sum + $signed({2'b00, POS_WRAP})) :
                    pos_over ? 32'(pos_sum - $signed({2'b00, POS_WRAP})) :
                    pos_sum[31:0];
            end
            // a wrap in the reading cycle keeps the flag set
            if (wrap_now) begin
                pos_wrap_o <= 1'b1;
            end else if (stat_rd) begin
                pos_wrap_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // object access
    logic sub0, hit_accel, hit_decel, hit_estop, hit_vmax, hit_win;
    logic hit_wtime, hit_kp, hit_ki, hit_cflt, hit_oflt, wr_ok, rd_ok;
    logic [31:0] rd_mux, status_word;

    assign sub0 = obj_subidx_i == VCL_SUB_MAIN;
    assign hit_accel = sub0 && obj_index_i == VCL_IDX_MAX_ACCEL;
    assign hit_decel = sub0 && (obj_index_i == VCL_IDX_MAX_DECEL ||
        obj_index_i == VCL_IDX_DECEL_ALIAS);
    assign hit_estop = sub0 && obj_index_i == VCL_IDX_ESTOP_DECEL;
    assign hit_vmax = sub0 && obj_index_i == VCL_IDX_MAX_VEL;
    assign hit_win = sub0 && obj_index_i == VCL_IDX_ERR_WIN;
    assign hit_wtime = sub0 && obj_index_i == VCL_IDX_WIN_TIME;
    assign hit_kp = obj_index_i == VCL_IDX_GAINS && obj_subidx_i == VCL_SUB_KP;
    assign hit_ki = obj_index_i == VCL_IDX_GAINS && obj_subidx_i == VCL_SUB_KI;
    assign hit_cflt = obj_index_i == VCL_IDX_CMD_FILT &&
        obj_subidx_i == VCL_SUB_FILT_SHIFT;
    assign hit_oflt = obj_index_i == VCL_IDX_OUT_FILT &&
        obj_subidx_i == VCL_SUB_FILT_SHIFT;
    assign wr_ok = hit_accel || hit_decel || hit_estop || hit_vmax ||
        hit_win || hit_wtime || hit_kp || hit_ki || hit_cflt || hit_oflt;

    assign status_word = (32'(vel_window_o) << VCL_STAT_VWIN_BIT) |
        (32'(pos_wrap_o) << VCL_STAT_WRAP_BIT);
    assign stat_rd = obj_rd_i && sub0 && obj_index_i == VCL_IDX_STATUS;

    always_comb begin
        rd_ok = 1'b1;
        rd_mux = '0;
        if (hit_accel) rd_mux = accel_reg;
        else if (hit_decel) rd_mux = decel_reg;
        else if (hit_estop) rd_mux = estop_reg;
        else if (hit_vmax) rd_mux = vmax_reg;
        else if (hit_win) rd_mux = win_reg;
        else if (hit_wtime) rd_mux = {16'h0000, win_time_reg};
        else if (hit_kp) rd_mux = {16'h0000, kp_reg};
        else if (hit_ki) rd_mux = {16'h0000, ki_reg};
        else if (hit_cflt) rd_mux = {28'h0, cmd_shift_reg};
        else if (hit_oflt) rd_mux = {28'h0, out_shift_reg};
        else if (stat_rd) rd_mux = status_word;
        else if (sub0 && obj_index_i == VCL_IDX_LIMITED_VEL)
            rd_mux = limited_vel_o;
        else if (sub0 && obj_index_i == VCL_IDX_VEL_ERROR)
            rd_mux = vel_error_o;
        else if (sub0 && obj_index_i == VCL_IDX_VEL_CMD)
            rd_mux = vcmd_reg;
        else if (sub0 && obj_index_i == VCL_IDX_POS_EFFORT)
            rd_mux = effort_reg;
        else rd_ok = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            accel_reg <= VCL_RST_RATE;
            decel_reg <= VCL_RST_RATE;
            estop_reg <= VCL_RST_RATE;
            vmax_reg <= VCL_RST_MAX_VEL;
            win_reg <= VCL_RST_ERR_WIN;
            win_time_reg <= VCL_RST_WIN_TIME;
            kp_reg <= VCL_RST_GAIN;
            ki_reg <= VCL_RST_GAIN;
            cmd_shift_reg <= VCL_RST_FILT_SHIFT;
            out_shift_reg <= VCL_RST_FILT_SHIFT;
            obj_ack_o <= 1'b0;
            obj_err_o <= 1'b0;
            obj_rdata_o <= '0;
        end else begin
            obj_ack_o <= obj_rd_i || obj_wr_i;
            obj_err_o <= (obj_wr_i && !wr_ok) || (obj_rd_i && !rd_ok);
            if (obj_rd_i) begin
                obj_rdata_o <= rd_mux;
            end
            if (obj_wr_i) begin
                if (hit_accel) accel_reg <= obj_wdata_i;
                if (hit_decel) decel_reg <= obj_wdata_i;
                if (hit_estop) estop_reg <= obj_wdata_i;
                if (hit_vmax) vmax_reg <= obj_wdata_i;
                if (hit_win) win_reg <= obj_wdata_i;
                if (hit_wtime) win_time_reg <= obj_wdata_i[15:0];
                if (hit_kp) kp_reg <= obj_wdata_i[15:0];
                if (hit_ki) ki_reg <= obj_wdata_i[15:0];
                if (hit_cflt) cmd_shift_reg <= obj_wdata_i[3:0];
                if (hit_oflt) out_shift_reg <= obj_wdata_i[3:0];
            end
        end
    end

endmodule // vcl_limiter

// [dv/vcl_chk.sv]
/*
 * Port checker for vcl_limiter: object port answer, refusals, servo
 * tick spacing, limited velocity timing and modulo position.
 * Assumes binding to vcl_limiter; one clock, sync active-high reset.
 */
`timescale 1ns/100ps

module vcl_chk #(
    parameter int SERVO_CYC = 8,
    parameter logic [31:0] POS_WRAP = 32'h0100_0000
) (
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic obj_rd_i, // read strobe
    input wire logic obj_wr_i, // write strobe
    input wire logic [15:0] obj_index_i, // index
    input wire logic obj_ack_o, // ack
    input wire logic obj_err_o, // error
    input wire logic [31:0] obj_rdata_o, // read data
    input wire logic servo_tick_o, // tick
    input wire logic signed [31:0] limited_vel_o, // limited cmd
    input wire logic [31:0] pos_count_o, // position
    input wire logic pos_wrap_o // wrap flag
);
    int tick_gap;
    logic gap_ok;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // cycles since the last tick
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tick_gap <= 0;
            gap_ok <= 1'b0;
        end else if (servo_tick_o) begin
            tick_gap <= 1;
            gap_ok <= 1'b1;
        end else begin
            tick_gap <= tick_gap + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_ack;
        (obj_rd_i || obj_wr_i) |=> obj_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_no_ack;
        !(obj_rd_i || obj_wr_i) |=> !obj_ack_o && !obj_err_o;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("stray ack");
    property p_ro_wr;
        obj_wr_i && obj_index_i == 16'h2230 |=> obj_err_o;
    endproperty
    a_ro_wr: assert property (p_ro_wr) else $error("ro write taken");
    property p_unmap;
        obj_rd_i && obj_index_i == 16'h0000 |=>
            obj_err_o && obj_rdata_o == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_rd_hold;
        !obj_rd_i |=> $stable(obj_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
    property p_tick;
        gap_ok |-> (servo_tick_o == (tick_gap == SERVO_CYC));
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing");
    property p_lim_tick;
        $changed(limited_vel_o) |-> $past(servo_tick_o);
    endproperty
    a_lim_tick: assert property (p_lim_tick) else $error("lim off tick");
    property p_pos;
        pos_count_o < POS_WRAP;
    endproperty
    a_pos: assert property (p_pos) else $error("position out of range");
    property p_wrap;
        $fell(pos_wrap_o) |-> $past(obj_rd_i) || $past(obj_rd_i, 2);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag dropped");

    c_err: cover property (obj_err_o);
    c_wrap: cover property ($fell(pos_wrap_o));
    c_lim: cover property ($changed(limited_vel_o));
endmodule // vcl_chk

bind vcl_limiter vcl_chk #(
    .SERVO_CYC(SERVO_CYC),
    .POS_WRAP(POS_WRAP)
) u_chk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .obj_rd_i(obj_rd_i),
    .obj_wr_i(obj_wr_i),
    .obj_index_i(obj_index_i),
    .obj_ack_o(obj_ack_o),
    .obj_err_o(obj_err_o),
    .obj_rdata_o(obj_rdata_o),
    .servo_tick_o(servo_tick_o),
    .limited_vel_o(limited_vel_o),
    .pos_count_o(pos_count_o),
    .pos_wrap_o(pos_wrap_o)
);

// [dv/vcl_master.sv]
/*
 * Network master model issuing one-cycle object accesses.
 * Assumes the answer comes on the edge after the strobe.
 */
`timescale 1ns/100ps

module vcl_master (
    input wire logic clk_i, // clock
    input wire logic ack_i, // ack
    input wire logic err_i, // error
    input wire logic [31:0] rdata_i, // read data
    output logic rd_o = 1'b0, // read strobe
    output logic wr_o = 1'b0, // write strobe
    output logic [15:0] idx_o = 16'h0000, // index
    output logic [7:0] sub_o = 8'h00, // sub-index
    output logic [31:0] wdata_o = 32'h0000_0000 // write data
);
    task automatic xfer(input logic wr, input logic [15:0] idx,
        input logic [7:0] sub, input logic [31:0] d,
        output logic [31:0] q, output logic e, output bit to);
        int n;
        @(posedge clk_i);
        #1;
        rd_o = !wr;
        wr_o = wr;
        idx_o = idx;
        sub_o = sub;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        wr_o = 1'b0;
        n = 0;
        while (ack_i !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        to = (n == 4);
        q = rdata_i;
        e = err_i;
        // released index and data lines show no stale value; sub-index keeps its last value
        idx_o = ~idx;
        wdata_o = ~d;
    endtask
endmodule // vcl_master

// [dv/tb_top.sv]
/*
 * Self-checking bench for vcl_limiter with a master model.
 * Assumes short servo and ms periods set by parameters.
 */
`timescale 1ns/100ps

module tb_top;
    import vcl_pkg::*;
    localparam logic [31:0] WRAP = 32'h0000_0100;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic rd, wr, ack, err, tick, win, wrapf;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [31:0] wd, rdata, pos;
    logic alt = 1'b0;
    logic estop = 1'b0;
    logic signed [31:0] pvel = 0, avel = 0, mvel = 0;
    logic signed [15:0] enc = 16'sh0000;
    logic signed [31:0] limv, verr, cur, a;
    logic [31:0] q;
    logic e;
    int errors = 0;
    int checked = 0;

    vcl_limiter #(.SERVO_HZ(10000), .SERVO_CYC(8), .MS_CYC(4),
        .POS_WRAP(WRAP)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .obj_rd_i(rd), .obj_wr_i(wr), .obj_index_i(idx),
        .obj_subidx_i(sub), .obj_wdata_i(wd), .obj_ack_o(ack),
        .obj_err_o(err), .obj_rdata_o(rdata), .alt_src_i(alt),
        .pos_loop_vel_i(pvel), .alt_vel_i(avel), .estop_i(estop),
        .motor_vel_i(mvel), .enc_delta_i(enc), .servo_tick_o(tick),
        .limited_vel_o(limv), .vel_error_o(verr), .cur_cmd_o(cur),
        .vel_window_o(win), .pos_count_o(pos), .pos_wrap_o(wrapf));
    vcl_master mst (.clk_i(clk_i), .ack_i(ack), .err_i(err),
        .rdata_i(rdata), .rd_o(rd), .wr_o(wr), .idx_o(idx),
        .sub_o(sub), .wdata_o(wd));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task results;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task acc(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d);
        bit to;
        mst.xfer(w, i, s, d, q, e, to);
        if (to) begin
            errors++;
            results();
        end
    endtask
    task ticks(input int k);
        int n;
        repeat (k) begin
            n = 0;
            while (tick !== 1'b1 && n < 40) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            if (n == 40) begin
                errors++;
                results();
            end
            @(posedge clk_i);
            #1;
        end
    endtask
    task reset_dut;
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_defaults;
        logic [15:0] ix [6] = '{16'h2100, 16'h2101, 16'h2102, 16'h2103,
            16'h2104, 16'h2105};
        logic [31:0] ex [6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
            32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h0000_0000};
        for (int k = 0; k < 6; k++) begin
            acc(1'b0, ix[k], 8'h00, 32'h0);
            chk(q, ex[k]);
        end
    endtask
    task t_port;
        acc(1'b1, 16'h60C6, 8'h00, 32'h0000_012C);
        acc(1'b0, 16'h2101, 8'h00, 32'h0);
        chk(q, 32'h0000_012C);
        acc(1'b1, 16'h2230, 8'h00, 32'h0000_0005);
        chk({31'b0, e}, 32'h1);
        acc(1'b0, 16'h0000, 8'h00, 32'h0);
        chk({31'b0, e}, 32'h1);
    endtask
    task t_pos_mode;
        acc(1'b1, 16'h2100, 8'h00, 32'h0000_0001);
        acc(1'b1, 16'h2101, 8'h00, 32'h0000_0001);
        acc(1'b1, 16'h2103, 8'h00, 32'h0000_03E8);
        pvel = 5000;
        ticks(2);
        chk(limv, 32'd1000);
        acc(1'b0, 16'h2230, 8'h00, 32'h0);
        chk(q, 32'd1000);
        acc(1'b0, 16'h606B, 8'h00, 32'h0);
        chk(q, 32'd5000);
        estop = 1'b1;
        pvel = -5000;
        ticks(2);
        chk(limv, -32'sd1000);
        estop = 1'b0;
        pvel = 0;
        ticks(2);
    endtask
    task t_alt;
        acc(1'b1, 16'h2100, 8'h00, 32'd100);
        acc(1'b1, 16'h2101, 8'h00, 32'd300);
        acc(1'b1, 16'h2102, 8'h00, 32'd50);
        alt = 1'b1;
        avel = 1000;
        pvel = 7;
        ticks(2);
        a = limv;
        ticks(1);
        chk(limv - a, 32'd100);
        acc(1'b0, 16'h60FA, 8'h00, 32'h0);
        chk(q, 32'd0);
        ticks(12);
        avel = 0;
        ticks(1);
        a = limv;
        ticks(1);
        chk(a - limv, 32'd300);
        ticks(4);
        avel = 1000;
        ticks(12);
        estop = 1'b1;
        ticks(1);
        a = limv;
        ticks(1);
        chk(a - limv, 32'd50);
        estop = 1'b0;
        alt = 1'b0;
        pvel = 0;
        ticks(2);
    endtask
    task t_window;
        int n;
        acc(1'b1, 16'h2104, 8'h00, 32'd10);
        acc(1'b1, 16'h2105, 8'h00, 32'd2);
        acc(1'b1, 16'h2381, 8'h01, 32'h0000_0100);
        mvel = 100;
        ticks(3);
        chk(verr, -32'sd100);
        chk({31'b0, win}, 32'h1);
        chk(cur, -32'sd100);
        acc(1'b0, 16'h2233, 8'h00, 32'h0);
        chk(q, -32'sd100);
        acc(1'b1, 16'h2381, 8'h02, 32'h0000_0100);
        ticks(2);
        chk(cur, -32'sd200);
        mvel = 0;
        n = 0;
        while (verr !== 32'h0 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n == 40) begin
            errors++;
            results();
        end
        chk({31'b0, win}, 32'h1);
        n = 0;
        while (win !== 1'b0 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n == 40) begin
            errors++;
            results();
        end
        chk(32'(n >= 8), 32'h1);
        acc(1'b1, 16'h2108, 8'h01, 32'h1);
        pvel = 1000;
        ticks(2);
        chk(limv, 32'd750);
    endtask
    task t_wrap;
        enc = 16'sh0040;
        ticks(1);
        a = pos;
        ticks(1);
        chk(pos, (a + 32'h40) % WRAP);
        ticks(4);
        enc = 16'sh0000;
        chk({31'b0, wrapf}, 32'h1);
        acc(1'b0, 16'h1002, 8'h00, 32'h0);
        chk({31'b0, q[21]}, 32'h1);
        acc(1'b0, 16'h1002, 8'h00, 32'h0);
        chk({31'b0, q[21]}, 32'h0);
    endtask

    initial begin
        reset_dut();
        t_defaults();
        t_port();
        t_pos_mode();
        t_alt();
        t_window();
        t_wrap();
        reset_dut();
        chk(limv, 32'h0);
        acc(1'b0, 16'h2103, 8'h00, 32'h0);
        chk(q, 32'h7FFF_FFFF);
        results();
    end
endmodule // tb_top
